// ### core/udct_timer.sv
// Up/down timer with absolute timestamps, two PWMs and two captures.
// Assumes one 250 MHz clock; capture pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none

`include "udct_params.svh"

module udct_timer
    import udct_pkg::*;
#(
    parameter int HALF_PERIOD = `UDCT_HALF_PERIOD,
    parameter int TICK_DIV = `UDCT_TICK_DIV
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic run_i,
    input wire logic [15:0] chan1_pulse_length_i,
    input wire logic chan1_update_i,
    input wire logic [15:0] chan4_pulse_length_i,
    input wire logic chan4_update_i,
    input wire logic chan2_capture_input_i,
    input wire logic chan3_capture_input_i,
    input wire logic chan2_flag_clear_i,
    input wire logic chan3_flag_clear_i,
    output logic [15:0] timer_count_o,
    output logic count_down_o,
    output logic [15:0] cycle_tally_low_o,
    output logic [15:0] cycle_tally_high_o,
    output logic [15:0] half_period_tally_o,
    output logic [31:0] leading_edge_stamp_o,
    output logic [31:0] high_phase_length_o,
    output logic [15:0] edge_stamp_low_o,
    output logic [15:0] edge_stamp_high_o,
    output logic chan2_flag_o,
    output logic chan3_flag_o,
    output logic zero_wrap_event_o,
    output logic period_limit_event_o,
    output logic chan2_event_o,
    output logic chan3_event_o,
    output logic sync_toggle_output_o,
    output logic chan1_pwm_o,
    output logic chan4_pwm_o
);

    // ------------------------------------------------------------
    // Sized constants
    // ------------------------------------------------------------
    localparam logic [15:0] PERIOD_LIMIT = 16'(HALF_PERIOD);
    localparam logic [31:0] FULL_PERIOD = 32'(2 * HALF_PERIOD);
    localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);

    udct_state_type st;
    udct_state_type next_st;

    logic ch2_rise;
    logic ch2_fall;
    logic ch3_rise;
    logic logic_unused_ch3_fall;
    logic tick;
    logic [15:0] next_count;
    logic at_limit;
    logic at_zero;
    logic [31:0] abs_time;
    logic match1;
    logic match4;
    logic [15:0] len1;
    logic [15:0] len4;

    // ------------------------------------------------------------
    // Capture pins
    // ------------------------------------------------------------
    // Both pins pass two flops before the edge logic sees them
    udct_edge_sync u_sync_ch2 (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(chan2_capture_input_i),
        .rise_o(ch2_rise),
        .fall_o(ch2_fall)
    );

    udct_edge_sync u_sync_ch3 (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(chan3_capture_input_i),
        .rise_o(ch3_rise),
        .fall_o(logic_unused_ch3_fall)
    );

    // ------------------------------------------------------------
    // Timer tick and count
    // ------------------------------------------------------------
    // Tick divided from the main clock; rate fixes the 224 steps
    assign tick = run_i && (st.div_cnt == TICK_LAST);

    // Next count value and the two turning points it reaches
    always_comb begin
        next_count = st.timer_count;
        at_limit = 1'b0;
        at_zero = 1'b0;
        if (st.dir == UDCT_UP) begin
            next_count = st.timer_count + 16'h0001;
            at_limit = (next_count == PERIOD_LIMIT);
        end else begin
            next_count = st.timer_count - 16'h0001;
            at_zero = (next_count == 16'h0000);
        end
    end

    // Compare matches fire when the count arrives at the value
    assign match1 = tick && (next_count == st.cmp1);
    assign match4 = tick && (next_count == st.cmp4);

    // ------------------------------------------------------------
    // Absolute event time
    // ------------------------------------------------------------
    // Built from the count, tally and direction bit of this very
    // cycle, so a capture at a turning point cannot mix old and new
    always_comb begin
        if (st.half_period_tally[`UDCT_DIR_BIT]) begin
            abs_time = st.cycle_tally - {16'h0000, st.timer_count};
        end else begin
            abs_time = st.cycle_tally + {16'h0000, st.timer_count};
        end
    end

    // ------------------------------------------------------------
    // Pulse length range checks
    // ------------------------------------------------------------
    // Channel 1 below 1 would never match while counting up
    always_comb begin
        len1 = chan1_pulse_length_i;
        if (len1 == 16'h0000) begin
            len1 = 16'h0001;
        end else if (len1 > PERIOD_LIMIT) begin
            len1 = PERIOD_LIMIT;
        end
        len4 = chan4_pulse_length_i;
        if (len4 > PERIOD_LIMIT) begin
            len4 = PERIOD_LIMIT;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ev = '0;

        // Divider runs only while the timer is enabled
        if (!run_i || tick) begin
            next_st.div_cnt = 16'h0000;
        end else begin
            next_st.div_cnt = st.div_cnt + 16'h0001;
        end

        // Counting and turning points
        if (tick) begin
            next_st.timer_count = next_count;
            if (at_limit) begin
                next_st.dir = UDCT_DOWN;
                next_st.cycle_tally = st.cycle_tally + FULL_PERIOD;
                next_st.half_period_tally[`UDCT_DIR_BIT] = 1'b1;
                next_st.sync_out = ~st.sync_out;
                next_st.ev.limit = 1'b1;
            end
            if (at_zero) begin
                next_st.dir = UDCT_UP;
                next_st.half_period_tally =
                    st.half_period_tally + 16'h0001;
                next_st.ev.zero_wrap = 1'b1;
            end
        end

        // Pending flags; a new request in the load cycle stays pending
        if (tick && at_zero) begin
            if (st.pend1) begin
                next_st.cmp1 = len1;
            end
            if (st.pend4) begin
                next_st.cmp4 = len4;
            end
            next_st.pend1 = 1'b0;
            next_st.pend4 = 1'b0;
        end
        if (chan1_update_i) begin
            next_st.pend1 = 1'b1;
        end
        if (chan4_update_i) begin
            next_st.pend4 = 1'b1;
        end

        // Channel 2: rising edge stamp, falling edge yields length;
        // both edges report, and a new result beats a clear
        if (chan2_flag_clear_i) begin
            next_st.flag2 = 1'b0;
        end
        if (ch2_rise) begin
            next_st.leading_edge_stamp = abs_time;
            next_st.flag2 = 1'b1;
            next_st.ev.chan2_done = 1'b1;
        end
        if (ch2_fall) begin
            next_st.high_phase_length =
                abs_time - st.leading_edge_stamp;
            next_st.flag2 = 1'b1;
            next_st.ev.chan2_done = 1'b1;
        end

        // Channel 3: full 32-bit stamp, carry crosses the halves
        if (chan3_flag_clear_i) begin
            next_st.flag3 = 1'b0;
        end
        if (ch3_rise) begin
            next_st.edge_stamp = abs_time;
            next_st.flag3 = 1'b1;
            next_st.ev.chan3_done = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st.div_cnt <= 16'h0000;
            st.dir <= UDCT_UP;
            st.timer_count <= `UDCT_COUNT_RST;
            st.cycle_tally <= `UDCT_CYCLE_TALLY_RST;
            st.half_period_tally <= `UDCT_HALF_TALLY_RST;
            st.cmp1 <= `UDCT_CHAN1_RST;
            st.cmp4 <= `UDCT_CHAN4_RST;
            st.pend1 <= 1'b0;
            st.pend4 <= 1'b0;
            st.leading_edge_stamp <= 32'h0000_0000;
            st.high_phase_length <= 32'h0000_0000;
            st.edge_stamp <= 32'h0000_0000;
            st.flag2 <= 1'b0;
            st.flag3 <= 1'b0;
            st.sync_out <= 1'b0;
            st.ev <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // PWM output units
    // ------------------------------------------------------------
    // Limit pulse reused from the count logic; match and limit
    // stay in step because both are decoded from the same tick
    udct_pwm_unit #(
        .SET_AT_LIMIT(1'b0)
    ) u_pwm_ch1 (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .match_i(match1),
        .limit_i(tick && at_limit),
        .pwm_o(chan1_pwm_o)
    );

    udct_pwm_unit #(
        .SET_AT_LIMIT(1'b1)
    ) u_pwm_ch4 (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .match_i(match4),
        .limit_i(tick && at_limit),
        .pwm_o(chan4_pwm_o)
    );

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign timer_count_o = st.timer_count;
    assign count_down_o = st.half_period_tally[`UDCT_DIR_BIT];
    assign cycle_tally_low_o = st.cycle_tally[15:0];
    assign cycle_tally_high_o = st.cycle_tally[31:16];
    assign half_period_tally_o = st.half_period_tally;
    assign leading_edge_stamp_o = st.leading_edge_stamp;
    assign high_phase_length_o = st.high_phase_length;
    assign edge_stamp_low_o = st.edge_stamp[15:0];
    assign edge_stamp_high_o = st.edge_stamp[31:16];
    assign chan2_flag_o = st.flag2;
    assign chan3_flag_o = st.flag3;
    assign zero_wrap_event_o = st.ev.zero_wrap;
    assign period_limit_event_o = st.ev.limit;
    assign chan2_event_o = st.ev.chan2_done;
    assign chan3_event_o = st.ev.chan3_done;
    assign sync_toggle_output_o = st.sync_out;
endmodule

`default_nettype wire

// ### core/udct_params.svh
// Constants of the up/down capture, timestamp and PWM timer.
// Assumes a 250 MHz main clock; included by the package and the design.
`ifndef UDCT_PARAMS_SVH
`define UDCT_PARAMS_SVH

// ----------------------------------------------------------------
// Clocking
// ----------------------------------------------------------------
`define UDCT_CLK_HZ 250000000
`define UDCT_FLL_MULT 116
`define UDCT_CRYSTAL_HZ 32768
`define UDCT_TIMER_HZ (`UDCT_FLL_MULT * `UDCT_CRYSTAL_HZ)
`define UDCT_REP_HZ 16969
// Main clock cycles per timer tick, rounded down (tick never too slow)
`define UDCT_TICK_DIV (`UDCT_CLK_HZ / `UDCT_TIMER_HZ)

// ----------------------------------------------------------------
// Period and reset values
// ----------------------------------------------------------------
`define UDCT_HALF_PERIOD ((`UDCT_TIMER_HZ / `UDCT_REP_HZ) / 2)
`define UDCT_CYCLE_TALLY_RST 32'h0000_0000
`define UDCT_HALF_TALLY_RST 16'h0000
`define UDCT_CHAN1_RST 16'h0001
`define UDCT_CHAN4_RST 16'h0000
`define UDCT_COUNT_RST 16'h0000
`define UDCT_DIR_BIT 0

`endif

// ### core/udct_pkg.sv
// Types shared by the up/down capture and PWM timer.
// Assumes the constants header sits beside it in core/.
`include "udct_params.svh"

package udct_pkg;

    // ------------------------------------------------------------
    // Count direction, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UDCT_UP = 2'h1,
        UDCT_DOWN = 2'h2
    } udct_dir_type;

    // Events signalled to the outside, one-cycle pulses
    typedef struct packed {
        logic zero_wrap;
        logic limit;
        logic chan2_done;
        logic chan3_done;
    } udct_event_type;

    // Whole state of the timer core
    typedef struct packed {
        logic [15:0] div_cnt;
        udct_dir_type dir;
        logic [15:0] timer_count;
        logic [31:0] cycle_tally;
        logic [15:0] half_period_tally;
        logic [15:0] cmp1;
        logic [15:0] cmp4;
        logic pend1;
        logic pend4;
        logic [31:0] leading_edge_stamp;
        logic [31:0] high_phase_length;
        logic [31:0] edge_stamp;
        logic flag2;
        logic flag3;
        logic sync_out;
        udct_event_type ev;
    } udct_state_type;

endpackage

// ### core/udct_edge_sync.sv
// Two-flop synchroniser for an outside pin with rising/falling detect.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module udct_edge_sync (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic pin_i,
    output logic rise_o,
    output logic fall_o
);
    // Stage 0 is read only by stage 1; stage 2 is the edge history
    logic [2:0] sync;
    logic [2:0] next_sync;

    // ------------------------------------------------------------
    // Shift chain
    // ------------------------------------------------------------
    always_comb begin
        next_sync = {sync[1:0], pin_i};
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync <= 3'h0;
        end else begin
            sync <= next_sync;
        end
    end

    // Edges compare the two settled stages only
    assign rise_o = sync[1] & ~sync[2];
    assign fall_o = ~sync[1] & sync[2];
endmodule

`default_nettype wire

// ### core/udct_pwm_unit.sv
// Output unit: toggles on compare match, resets or sets at the limit.
// Assumes match and limit are single-cycle pulses from the timer core.
`timescale 1ns/1ps
`default_nettype none

module udct_pwm_unit #(
    parameter bit SET_AT_LIMIT = 1'b0
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic match_i,
    input wire logic limit_i,
    output logic pwm_o
);
    logic level;
    logic next_level;

    // ------------------------------------------------------------
    // Output level
    // ------------------------------------------------------------
    // Limit action wins over a coinciding match, so a full-length
    // pulse does not flip back at the turning point
    always_comb begin
        next_level = level;
        if (limit_i) begin
            next_level = SET_AT_LIMIT;
        end else if (match_i) begin
            next_level = ~level;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            level <= 1'b0;
        end else begin
            level <= next_level;
        end
    end

    assign pwm_o = level;
endmodule

`default_nettype wire

// ### sim/udct_timer_assertions.sv
// Concurrent checks on the ports of the up/down capture and PWM timer.
// Assumes it is bound to udct_timer with the same two parameters.
`timescale 1ns/1ps
`default_nettype none

module udct_timer_assertions #(
    parameter int HALF_PERIOD = 112,
    parameter int TICK_DIV = 65
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic chan3_flag_clear_i,
    input wire logic [15:0] timer_count_o,
    input wire logic count_down_o,
    input wire logic [15:0] cycle_tally_low_o,
    input wire logic [15:0] cycle_tally_high_o,
    input wire logic [15:0] half_period_tally_o,
    input wire logic chan2_flag_o,
    input wire logic chan3_flag_o,
    input wire logic zero_wrap_event_o,
    input wire logic period_limit_event_o,
    input wire logic chan2_event_o,
    input wire logic chan3_event_o,
    input wire logic sync_toggle_output_o,
    input wire logic chan1_pwm_o,
    input wire logic chan4_pwm_o
);
    // ------------------------------------------------------------
    // Shared clocking and helper values
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic [31:0] tally;
    // Both tally halves read as one value so a lost carry shows
    assign tally = {cycle_tally_high_o, cycle_tally_low_o};

    // ------------------------------------------------------------
    // Count, tallies and events
    // ------------------------------------------------------------
    a_limit_at_top: assert property (period_limit_event_o |->
        timer_count_o == 16'(HALF_PERIOD) && count_down_o)
        else $error("limit event away from the top count");
    a_count_range: assert property (timer_count_o <= 16'(HALF_PERIOD))
        else $error("count above the period limit");
    a_count_step: assert property ($changed(timer_count_o) |->
        (timer_count_o - $past(timer_count_o) == 16'h0001) ||
        ($past(timer_count_o) - timer_count_o == 16'h0001))
        else $error("count moved by more than one");
    a_count_hold: assert property ($changed(timer_count_o) |=>
        $stable(timer_count_o))
        else $error("count stepped on two edges in a row");
    a_tally_step: assert property (period_limit_event_o |->
        tally == $past(tally) + 32'(2 * HALF_PERIOD))
        else $error("cycle tally not advanced by one period");
    a_wrap_half_inc: assert property (zero_wrap_event_o |->
        timer_count_o == 16'h0000 && !count_down_o &&
        half_period_tally_o == $past(half_period_tally_o) + 16'h0001)
        else $error("zero wrap without half tally step");
    a_sync_follows: assert property (
        $changed(sync_toggle_output_o) == period_limit_event_o)
        else $error("sync output out of step with limit");

    // ------------------------------------------------------------
    // Output units and capture flags
    // ------------------------------------------------------------
    a_ch1_reset: assert property (period_limit_event_o |->
        ##[0:1] !chan1_pwm_o)
        else $error("channel 1 not reset at the limit");
    a_ch4_set: assert property (period_limit_event_o |->
        ##[0:1] chan4_pwm_o)
        else $error("channel 4 not set at the limit");
    a_ch2_flag: assert property (chan2_event_o |-> chan2_flag_o)
        else $error("channel 2 result without flag");
    a_ch3_flag: assert property (chan3_event_o |-> chan3_flag_o)
        else $error("channel 3 result without flag");
    a_ch3_clear: assert property (chan3_flag_clear_i ##1
        !chan3_event_o |-> !chan3_flag_o)
        else $error("channel 3 flag survived a clear");

    // Main scenarios reached
    c_limit: cover property (period_limit_event_o);
    c_ch2: cover property (chan2_event_o);
    c_ch3: cover property (chan3_event_o);
endmodule
`default_nettype wire

// ### sim/udct_pin_model.sv
// Model of the outside world driving the two capture pins.
// Assumes the bench posts the wanted levels just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module udct_pin_model (
    input wire logic clk_i,
    input wire logic [1:0] level_i,
    output logic chan2_pin_o,
    output logic chan3_pin_o
);
    // Pins start low so the timer never sees an unknown level
    initial begin
        chan2_pin_o = 1'b0;
        chan3_pin_o = 1'b0;
    end

    // Change on the falling edge, half a cycle from any sampling edge
    always @(negedge clk_i) begin
        chan2_pin_o <= level_i[0];
        chan3_pin_o <= level_i[1];
    end
endmodule
`default_nettype wire

// ### sim/udct_timer_bench.sv
// Self-checking bench for the up/down capture and PWM timer.
// Assumes the pin model and the assertion checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

`include "udct_params.svh"

module udct_timer_bench;
    import udct_pkg::*;
    // Short counts keep a full period at 64 clocks
    localparam int HP = 8;
    localparam int TD = 4;
    logic clk_i, arst_n_i = 1'b0, run_i = 1'b0;
    logic [15:0] len1 = 16'h0000, len4 = 16'h0000;
    logic upd1 = 1'b0, upd4 = 1'b0, clr2 = 1'b0, clr3 = 1'b0;
    logic [1:0] pin_req = 2'h0;
    logic pin2, pin3, down, f2, f3, wrap, lim, ev2, ev3, sync, pwm1, pwm4;
    logic [15:0] cnt, tlo, thi, half, s3lo, s3hi;
    logic [31:0] lead, high_len;
    logic [3:0] evs;
    int edge_n = 0;
    int n_tests = 0;
    int n_mismatch = 0;

    // ------------------------------------------------------------
    // Design, pin model and clock
    // ------------------------------------------------------------
    udct_timer #(.HALF_PERIOD(HP), .TICK_DIV(TD)) i_dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .run_i(run_i),
        .chan1_pulse_length_i(len1), .chan1_update_i(upd1),
        .chan4_pulse_length_i(len4), .chan4_update_i(upd4),
        .chan2_capture_input_i(pin2), .chan3_capture_input_i(pin3),
        .chan2_flag_clear_i(clr2), .chan3_flag_clear_i(clr3),
        .timer_count_o(cnt), .count_down_o(down),
        .cycle_tally_low_o(tlo), .cycle_tally_high_o(thi),
        .half_period_tally_o(half), .leading_edge_stamp_o(lead),
        .high_phase_length_o(high_len), .edge_stamp_low_o(s3lo),
        .edge_stamp_high_o(s3hi), .chan2_flag_o(f2), .chan3_flag_o(f3),
        .zero_wrap_event_o(wrap), .period_limit_event_o(lim),
        .chan2_event_o(ev2), .chan3_event_o(ev3),
        .sync_toggle_output_o(sync), .chan1_pwm_o(pwm1),
        .chan4_pwm_o(pwm4));
    udct_pin_model i_pins (.clk_i(clk_i), .level_i(pin_req),
        .chan2_pin_o(pin2), .chan3_pin_o(pin3));
    assign evs = {ev3, ev2, wrap, lim};

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Edges since run started; its quotient by TD is absolute time
    always @(posedge clk_i) if (run_i) edge_n <= edge_n + 1;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Bounded wait for a one-cycle event pulse
    task automatic wait_ev(input int which);
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_i);
            #1;
            if (evs[which] === 1'b1) return;
        end
        n_mismatch++;
        $display("mismatch event %0d expected 1 seen 0", which);
        tally_and_finish();
    endtask

    // Move a pin so the timer sees it at tick ph of the period;
    // landing on a tick boundary keeps the sync delay inside one tick
    task automatic pin_at(input int ph, input int which, input logic lvl,
                          output int p);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_i);
            #1;
            if ((edge_n + 1) % (2 * HP * TD) == ph * TD) begin
                pin_req[which] = lvl;
                p = (edge_n + 1) / TD;
                return;
            end
        end
        n_mismatch++;
        $display("mismatch pin alignment expected 1 seen 0");
        tally_and_finish();
    endtask

    // Clocks of channel 1 high and channel 4 low over n clocks
    task automatic measure(input int n, output int hi1, output int lo4);
        hi1 = 0;
        lo4 = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            #1;
            if (pwm1 === 1'b1) hi1++;
            if (pwm4 === 1'b0) lo4++;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        check("count", cnt, 0);
        check("cycle tally", {thi, tlo}, 0);
        check("half tally", half, 0);
        check("duty steps", 2 * `UDCT_HALF_PERIOD, 224);
        $display("test_reset done");
    endtask

    task automatic test_count();
        @(negedge clk_i);
        run_i = 1'b1;
        wait_ev(0);
        check("limit edge", edge_n, HP * TD);
        check("top count", cnt, HP);
        check("tally one", {thi, tlo}, 2 * HP);
        check("down flag", down, 1);
        check("sync", sync, 1);
        wait_ev(1);
        check("half tally", half, 2);
        check("up flag", down, 0);
        wait_ev(0);
        check("tally two", {thi, tlo}, 4 * HP);
        check("sync back", sync, 0);
        $display("test_count done");
    endtask

    task automatic test_capture3();
        int p;
        pin_at(12, 1, 1'b1, p);
        wait_ev(3);
        check("stamp down", {s3hi, s3lo}, p);
        check("flag 3", f3, 1);
        @(negedge clk_i);
        clr3 = 1'b1;
        @(negedge clk_i);
        clr3 = 1'b0;
        check("flag 3 clear", f3, 0);
        pin_at(3, 1, 1'b0, p);
        pin_at(6, 1, 1'b1, p);
        wait_ev(3);
        check("stamp up", {s3hi, s3lo}, p);
        pin_req[1] = 1'b0;
        // Edge on the very tick that turns the count at the top
        pin_at(HP, 1, 1'b1, p);
        wait_ev(3);
        check("stamp turn", {s3hi, s3lo}, p);
        pin_req[1] = 1'b0;
        $display("test_capture3 done");
    endtask

    task automatic test_capture2();
        int p1;
        int p2;
        pin_at(HP + 1, 0, 1'b1, p1);
        wait_ev(2);
        check("leading edge", lead, p1);
        check("flag 2 lead", f2, 1);
        pin_at(5, 0, 1'b0, p2);
        wait_ev(2);
        check("high phase", high_len, p2 - p1);
        check("flag 2", f2, 1);
        @(negedge clk_i);
        clr2 = 1'b1;
        @(negedge clk_i);
        clr2 = 1'b0;
        check("flag 2 clear", f2, 0);
        $display("test_capture2 done");
    endtask

    task automatic test_pwm();
        int hi1;
        int lo4;
        wait_ev(1);
        @(negedge clk_i);
        len1 = 16'h0003;
        len4 = 16'h0005;
        upd1 = 1'b1;
        upd4 = 1'b1;
        @(negedge clk_i);
        upd1 = 1'b0;
        upd4 = 1'b0;
        wait_ev(0);
        // Old length on the way down, new one on the way up
        measure(2 * HP * TD, hi1, lo4);
        check("ch1 mixed", hi1, (1 + 3) * TD);
        measure(2 * HP * TD, hi1, lo4);
        check("ch1 pulse", hi1, 2 * 3 * TD);
        check("ch4 pulse", lo4, 2 * 5 * TD);
        $display("test_pwm done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(negedge clk_i);
        arst_n_i = 1'b1;
        @(negedge clk_i);
        test_reset();
        test_count();
        test_capture3();
        test_capture2();
        test_pwm();
        tally_and_finish();
    end
endmodule

bind udct_timer udct_timer_assertions #(
    .HALF_PERIOD(HALF_PERIOD), .TICK_DIV(TICK_DIV)) i_chk (
    .clk_i(clk_i), .arst_n_i(arst_n_i),
    .chan3_flag_clear_i(chan3_flag_clear_i),
    .timer_count_o(timer_count_o), .count_down_o(count_down_o),
    .cycle_tally_low_o(cycle_tally_low_o),
    .cycle_tally_high_o(cycle_tally_high_o),
    .half_period_tally_o(half_period_tally_o),
    .chan2_flag_o(chan2_flag_o), .chan3_flag_o(chan3_flag_o),
    .zero_wrap_event_o(zero_wrap_event_o),
    .period_limit_event_o(period_limit_event_o),
    .chan2_event_o(chan2_event_o), .chan3_event_o(chan3_event_o),
    .sync_toggle_output_o(sync_toggle_output_o),
    .chan1_pwm_o(chan1_pwm_o), .chan4_pwm_o(chan4_pwm_o));
`default_nettype wire
